/* core/uart_idle_line_multiproc.sv */
// UART transceiver with idle-line multiprocessor format and Wishbone registers
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "uart_consts.svh"
module uart_idle_line_multiproc (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire uart_pkg::wb_req_t wb_req,
  output uart_pkg::wb_rsp_t      wb_rsp,
  input  wire logic              serial_receive_pin,
  output logic                   serial_transmit_pin,
  output logic                   rx_irq,
  output logic                   tx_irq,
  output logic                   start_irq,
  output logic                   tx_done_irq,
  output logic                   wake_req
);
  import uart_pkg::*;

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  ctrl_t       ctrl_reg;
  ctrl_t       ctrl_next;
  logic [15:0] baud_reg;
  logic        rx_s1_reg;
  logic        rx_s2_reg;
  logic        rx_prev_reg;
  rx_state_t   rx_state;
  logic [15:0] rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_par_reg;
  logic        rx_fe_reg;
  logic        rx_addr_reg;
  logic        idle_seen_reg;
  logic        idle_arm_reg;
  logic [3:0]  idle_cnt_reg;
  tx_state_t   tx_state;
  logic [15:0] tx_cnt_reg;
  logic [3:0]  tx_bit_reg;
  logic [7:0]  tx_sh_reg;
  logic [7:0]  txbuf_reg;
  logic [7:0]  rxbuf_reg;
  logic        tx_empty_reg;
  logic        rx_flag_reg;
  logic        start_flag_reg;
  logic        txdone_flag_reg;
  logic        fe_reg;
  logic        pe_reg;
  logic        oe_reg;
  logic        brk_reg;
  logic        idle_tag_reg;
  logic [19:0] gap_cyc_reg;

  // Power-up clear released through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Bus decode
  wire        req       = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  wire        wr        = req & wb_req.we;
  wire        rd        = req & ~wb_req.we;
  wire [15:0] wm16      = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  wire        hit_ctrl  = wb_req.adr == `OFS_CTRL;
  wire        hit_baud  = wb_req.adr == `OFS_BAUD;
  wire        hit_stat  = wb_req.adr == `OFS_STAT;
  wire        hit_rxbuf = wb_req.adr == `OFS_RXBUF;
  wire        hit_txbuf = wb_req.adr == `OFS_TXBUF;
  wire        txw       = wr & hit_txbuf & wb_req.sel[0];
  wire        rd_rxbuf  = rd & hit_rxbuf;
  wire [15:0] clr       = (wr & hit_stat) ? (wb_req.dat[15:0] & wm16 & `STAT_W1C_MASK) : 16'h0;

  // Operating mode
  wire hold    = ctrl_reg.soft_reset_hold;
  wire run     = ~hold & ~ctrl_reg.sync_mode_select;
  wire mp_idle = ctrl_reg.multiproc_format_select == `MP_IDLE_LINE;
  wire [3:0] last_bit = ctrl_reg.seven_bit ? 4'h6 : 4'h7;

  // Bit position in the data field for the selected order
  function automatic logic [2:0] bit_pos(input logic [3:0] b, input logic msb,
                                         input logic [3:0] top);
    logic [3:0] r;
    r = msb ? (top - b) : b;
    return r[2:0];
  endfunction : bit_pos

  // Receive completion terms
  wire        rx_tick  = rx_cnt_reg == 16'h0;
  wire        fall     = rx_prev_reg & ~rx_s2_reg;
  wire        start_ev = run & (rx_state == R_IDLE) & fall;
  wire [7:0]  rx_data  = ctrl_reg.seven_bit ? {1'b0, rx_sh_reg[6:0]} : rx_sh_reg;
  wire        rx_exp   = ^rx_data ^ ~ctrl_reg.parity_even;
  wire        rx_pe    = ctrl_reg.parity_enable & (rx_par_reg != rx_exp);
  wire        rx_fe    = rx_fe_reg | ~rx_s2_reg;
  wire        rx_err   = rx_fe | rx_pe;
  wire        rx_done  = (rx_state == R_STOP) & rx_tick &
                         ~(ctrl_reg.two_stop & (rx_bit_reg == 4'h0));
  wire        rx_brk   = (rx_data == 8'h0) & ~(ctrl_reg.parity_enable & rx_par_reg) & ~rx_s2_reg;
  wire        accept   = ~(ctrl_reg.dormant_receive & mp_idle) | rx_addr_reg;
  wire        store    = rx_done & accept &
                         (~rx_err | ctrl_reg.erroneous_char_accept_enable);
  wire        idle_ev  = run & (rx_state == R_IDLE) & idle_arm_reg & rx_s2_reg & ~fall &
                         rx_tick & (idle_cnt_reg == `IDLE_DETECT_BITS - 4'h1);

  // Transmit terms
  wire        tx_tick  = tx_cnt_reg == 16'h0;
  wire        load     = run & (tx_state == T_IDLE) & ~tx_empty_reg;
  wire        gap_load = ctrl_reg.tx_address_mark & mp_idle;
  wire [7:0]  tx_data  = ctrl_reg.seven_bit ? {1'b0, tx_sh_reg[6:0]} : tx_sh_reg;
  wire        tx_par   = ^tx_data ^ ~ctrl_reg.parity_even;
  wire        mark_clr = (tx_state == T_GAP) & tx_tick &
                         (tx_bit_reg == `IDLE_GAP_BITS - 4'h1);
  wire        tx_end   = (tx_state == T_STOP) & tx_tick &
                         ~(ctrl_reg.two_stop & (tx_bit_reg == 4'h0));
  wire [15:0] reload   = baud_reg - 16'h1;

  // Control next value: auto clear, then software write, then hold forcing
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (mark_clr)
      ctrl_next.tx_address_mark = 1'b0;
    if (wr && hit_ctrl)
      ctrl_next = ctrl_t'((ctrl_reg & ~wm16) | (wb_req.dat[15:0] & wm16));
    if (ctrl_next.soft_reset_hold)
    begin
      ctrl_next.rx_irq_enable = 1'b0;
      ctrl_next.tx_irq_enable = 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= ctrl_t'(`CTRL_RESET);
      baud_reg <= `BAUD_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      if (wr && hit_baud)
        baud_reg <= (baud_reg & ~wm16) | (wb_req.dat[15:0] & wm16);
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg   <= serial_receive_pin;
      rx_s2_reg   <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  // Receive shifter and idle-line detector
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state      <= R_IDLE;
      rx_cnt_reg    <= 16'h0;
      rx_bit_reg    <= 4'h0;
      rx_sh_reg     <= 8'h0;
      rx_par_reg    <= 1'b0;
      rx_fe_reg     <= 1'b0;
      rx_addr_reg   <= 1'b0;
      idle_seen_reg <= 1'b1;
      idle_arm_reg  <= 1'b0;
      idle_cnt_reg  <= 4'h0;
    end
    else if (!run)
    begin
      rx_state      <= R_IDLE;
      idle_seen_reg <= 1'b1;
      idle_arm_reg  <= 1'b0;
      idle_cnt_reg  <= 4'h0;
    end
    else
    begin
      unique case (rx_state)
        R_IDLE:
          if (fall)
          begin
            rx_state      <= R_START;
            rx_cnt_reg    <= baud_reg >> 1;
            rx_addr_reg   <= mp_idle & idle_seen_reg;
            idle_seen_reg <= 1'b0;
            idle_arm_reg  <= 1'b0;
            idle_cnt_reg  <= 4'h0;
          end
          else if (idle_arm_reg)
          begin
            if (!rx_s2_reg)
              idle_cnt_reg <= 4'h0;
            else if (rx_tick)
            begin
              rx_cnt_reg <= reload;
              if (idle_ev)
              begin
                idle_arm_reg  <= 1'b0;
                idle_seen_reg <= 1'b1;
              end
              else
                idle_cnt_reg <= idle_cnt_reg + 4'h1;
            end
            else
              rx_cnt_reg <= rx_cnt_reg - 16'h1;
          end
        R_START:
          if (rx_tick)
          begin
            rx_state   <= rx_s2_reg ? R_IDLE : R_DATA;
            rx_cnt_reg <= reload;
            rx_bit_reg <= 4'h0;
            rx_sh_reg  <= 8'h0;
          end
          else
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
        R_DATA:
          if (rx_tick)
          begin
            rx_cnt_reg <= reload;
            rx_sh_reg[bit_pos(rx_bit_reg, ctrl_reg.msb_first_select, last_bit)] <= rx_s2_reg;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == last_bit)
            begin
              rx_state   <= ctrl_reg.parity_enable ? R_PAR : R_STOP;
              rx_bit_reg <= 4'h0;
              rx_fe_reg  <= 1'b0;
            end
          end
          else
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
        R_PAR:
          if (rx_tick)
          begin
            rx_cnt_reg <= reload;
            rx_par_reg <= rx_s2_reg;
            rx_state   <= R_STOP;
          end
          else
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
        R_STOP:
          if (rx_tick)
          begin
            rx_cnt_reg <= reload;
            rx_fe_reg  <= rx_fe;
            rx_bit_reg <= 4'h1;
            if (rx_done)
            begin
              rx_state     <= R_IDLE;
              idle_arm_reg <= 1'b1;
              idle_cnt_reg <= 4'h0;
            end
          end
          else
            rx_cnt_reg <= rx_cnt_reg - 16'h1;
      endcase
    end
  end

  // Transmit shifter with idle-frame generation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state            <= T_IDLE;
      tx_cnt_reg          <= 16'h0;
      tx_bit_reg          <= 4'h0;
      tx_sh_reg           <= 8'h0;
      serial_transmit_pin <= 1'b1;
    end
    else if (!run)
    begin
      tx_state            <= T_IDLE;
      serial_transmit_pin <= 1'b1;
    end
    else
    begin
      tx_cnt_reg <= tx_tick ? reload : tx_cnt_reg - 16'h1;
      unique case (tx_state)
        T_IDLE:
        begin
          tx_cnt_reg <= reload;
          tx_bit_reg <= 4'h0;
          if (load)
          begin
            tx_sh_reg           <= txbuf_reg;
            tx_state            <= gap_load ? T_GAP : T_START;
            serial_transmit_pin <= gap_load;
          end
        end
        T_GAP:
          if (tx_tick)
          begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (mark_clr)
            begin
              tx_state            <= T_START;
              serial_transmit_pin <= 1'b0;
            end
          end
        T_START:
          if (tx_tick)
          begin
            tx_state            <= T_DATA;
            tx_bit_reg          <= 4'h0;
            serial_transmit_pin <= tx_sh_reg[bit_pos(4'h0, ctrl_reg.msb_first_select, last_bit)];
          end
        T_DATA:
          if (tx_tick)
          begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            serial_transmit_pin <=
              tx_sh_reg[bit_pos(tx_bit_reg + 4'h1, ctrl_reg.msb_first_select, last_bit)];
            if (tx_bit_reg == last_bit)
            begin
              tx_state            <= ctrl_reg.parity_enable ? T_PAR : T_STOP;
              tx_bit_reg          <= 4'h0;
              serial_transmit_pin <= ctrl_reg.parity_enable ? tx_par : 1'b1;
            end
          end
        T_PAR:
          if (tx_tick)
          begin
            tx_state            <= T_STOP;
            serial_transmit_pin <= 1'b1;
          end
        T_STOP:
          if (tx_tick)
          begin
            tx_bit_reg <= 4'h1;
            if (tx_end)
              tx_state <= T_IDLE;
          end
      endcase
    end
  end

  // Flags and holding buffers; hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_empty_reg    <= 1'b1;
      rx_flag_reg     <= 1'b0;
      start_flag_reg  <= 1'b0;
      txdone_flag_reg <= 1'b0;
      fe_reg          <= 1'b0;
      pe_reg          <= 1'b0;
      oe_reg          <= 1'b0;
      brk_reg         <= 1'b0;
      idle_tag_reg    <= 1'b0;
      txbuf_reg       <= 8'h0;
      rxbuf_reg       <= 8'h0;
    end
    else
    begin
      if (txw)
        txbuf_reg <= wb_req.dat[7:0];
      if (store)
        rxbuf_reg <= rx_data;
      if (hold)
      begin
        tx_empty_reg    <= 1'b1;
        rx_flag_reg     <= 1'b0;
        start_flag_reg  <= 1'b0;
        txdone_flag_reg <= 1'b0;
        fe_reg          <= 1'b0;
        pe_reg          <= 1'b0;
        oe_reg          <= 1'b0;
        brk_reg         <= 1'b0;
      end
      else
      begin
        tx_empty_reg    <= load | (tx_empty_reg & ~txw);
        rx_flag_reg     <= store | (rx_flag_reg & ~clr[1] & ~rd_rxbuf);
        start_flag_reg  <= start_ev | (start_flag_reg & ~clr[2]);
        txdone_flag_reg <= (tx_end & tx_empty_reg) | (txdone_flag_reg & ~clr[3]);
        fe_reg          <= (store & rx_fe) | (fe_reg & ~clr[4]);
        pe_reg          <= (store & rx_pe) | (pe_reg & ~clr[5]);
        oe_reg          <= (store & rx_flag_reg & ~rd_rxbuf) | (oe_reg & ~clr[6]);
        brk_reg         <= (rx_done & rx_brk) | (brk_reg & ~clr[7]);
      end
      if (idle_ev)
        idle_tag_reg <= 1'b1;
      else if (store)
        idle_tag_reg <= rx_addr_reg & mp_idle;
    end
  end

  // Status word; timeout flags belong to auto-baud and stay cleared
  wire stat_t stat_w = stat_t'({2'h0, rx_state != R_IDLE, tx_state != T_IDLE,
                                fe_reg | pe_reg | oe_reg | brk_reg, idle_tag_reg,
                                1'b0, 1'b0, brk_reg, oe_reg, pe_reg, fe_reg,
                                txdone_flag_reg, start_flag_reg, rx_flag_reg,
                                tx_empty_reg});
  wire [31:0] rdata = hit_ctrl  ? {16'h0, ctrl_reg} :
                      hit_baud  ? {16'h0, baud_reg} :
                      hit_stat  ? {16'h0, stat_w} :
                      hit_rxbuf ? {24'h0, rxbuf_reg} :
                      hit_txbuf ? {24'h0, txbuf_reg} : 32'h0;

  // Bus answer, interrupt requests and wake pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_rsp      <= '0;
      rx_irq      <= 1'b0;
      tx_irq      <= 1'b0;
      start_irq   <= 1'b0;
      tx_done_irq <= 1'b0;
      wake_req    <= 1'b0;
    end
    else
    begin
      wb_rsp.ack  <= req;
      wb_rsp.dat  <= rd ? rdata : 32'h0;
      rx_irq      <= rx_flag_reg & ctrl_reg.rx_irq_enable;
      tx_irq      <= tx_empty_reg & ctrl_reg.tx_irq_enable;
      start_irq   <= start_flag_reg & ctrl_reg.start_irq_enable;
      tx_done_irq <= txdone_flag_reg & ctrl_reg.tx_done_irq_enable;
      wake_req    <= start_ev;
    end
  end

  // Cycle count of the idle frame, for checking only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_cyc_reg <= 20'h0;
    else
      gap_cyc_reg <= (tx_state == T_GAP) ? gap_cyc_reg + 20'h1 : 20'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_hold_flags;
    hold |=> tx_empty_reg && !rx_flag_reg && !fe_reg && !pe_reg && !oe_reg && !brk_reg
             && !ctrl_reg.rx_irq_enable && !ctrl_reg.tx_irq_enable;
  endproperty
  a_hold_flags: assert property (p_hold_flags) else $error("hold did not clear flags");

  property p_sync_off;
    (ctrl_reg.sync_mode_select || hold) |=> tx_state == T_IDLE && rx_state == R_IDLE;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("shifters ran outside UART mode");

  property p_gap_len;
    $fell(tx_state == T_GAP) && run |-> gap_cyc_reg == 20'(baud_reg) * 20'(`IDLE_GAP_BITS);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("idle frame length wrong");

  property p_gap_mark;
    tx_state == T_GAP |-> serial_transmit_pin;
  endproperty
  a_gap_mark: assert property (p_gap_mark) else $error("line not mark in idle frame");

  property p_mark_clear;
    tx_state == T_GAP ##1 tx_state == T_START |-> !ctrl_reg.tx_address_mark
                                                  && !serial_transmit_pin;
  endproperty
  a_mark_clear: assert property (p_mark_clear) else $error("address mark not cleared");

  property p_dormant_drop;
    rx_done && ctrl_reg.dormant_receive && mp_idle && !rx_addr_reg
      |=> $stable(rxbuf_reg) && !$rose(rx_flag_reg);
  endproperty
  a_dormant_drop: assert property (p_dormant_drop) else $error("dormant data stored");

  property p_addr_store;
    rx_done && rx_addr_reg && !rx_err && !hold |=> rx_flag_reg && rxbuf_reg == $past(rx_data)
                                                   && idle_tag_reg;
  endproperty
  a_addr_store: assert property (p_addr_store) else $error("address not stored");

  property p_err_drop;
    rx_done && rx_err && !ctrl_reg.erroneous_char_accept_enable |=> $stable(rxbuf_reg);
  endproperty
  a_err_drop: assert property (p_err_drop) else $error("errored character stored");

  property p_idle_detect;
    idle_ev |=> idle_tag_reg && idle_seen_reg && !idle_arm_reg;
  endproperty
  a_idle_detect: assert property (p_idle_detect) else $error("idle line not flagged");

  property p_idle_restart;
    start_ev |=> idle_cnt_reg == 4'h0 && rx_state == R_START && !idle_seen_reg;
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("idle count not restarted");

  property p_dormant_kept;
    !(wr && hit_ctrl) |=> $stable(ctrl_reg.dormant_receive);
  endproperty
  a_dormant_kept: assert property (p_dormant_kept) else $error("dormant bit changed");

endmodule : uart_idle_line_multiproc

/* core/uart_consts.svh */
// Register offsets, reset values and bit counts of the UART transceiver
//
// Behaviour
// - UART runs only while sync select clear
// - Both directions share one baud divisor
// - Reset sets soft reset hold bit
// - Hold forces tx empty, clears flags, rx and tx irq enables
// - Clearing hold starts normal operation
// - Start, 7/8 data, parity, 1/2 stop
// - Bit order selects LSB or MSB first
// - Separate shift and holding registers per direction
// - Independent receive, transmit, start, done requests
// - Start edge gives wake request
// - Idle-line format when format field is 01
// - Ten marks after stop set idle tag
// - Receive bit timer stops after idle line
// - First character after idle is an address
// - Dormant: data characters shifted, never stored
// - Address stored, flag set, errors if accepted
// - Errored address dropped when error accept clear
// - Hardware never changes dormant bit
// - Dormant cleared mid-character still flags it
// - Address mark sends eleven idle bits first
// - Address mark clears at start bit
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

`define OFS_CTRL         8'h00
`define OFS_BAUD         8'h04
`define OFS_STAT         8'h08
`define OFS_RXBUF        8'h0c
`define OFS_TXBUF        8'h10

`define CTRL_RESET       16'h0001
`define BAUD_RESET       16'h0364
`define STAT_W1C_MASK    16'h00fe

`define IDLE_DETECT_BITS 4'ha
`define IDLE_GAP_BITS    4'hb
`define MP_IDLE_LINE     2'h1

`endif

/* core/uart_pkg.sv */
// Types shared by the UART transceiver
package uart_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic       tx_done_irq_enable;
    logic       start_irq_enable;
    logic       tx_irq_enable;
    logic       rx_irq_enable;
    logic       tx_address_mark;
    logic       erroneous_char_accept_enable;
    logic       dormant_receive;
    logic [1:0] multiproc_format_select;
    logic       two_stop;
    logic       msb_first_select;
    logic       parity_even;
    logic       parity_enable;
    logic       seven_bit;
    logic       sync_mode_select;
    logic       soft_reset_hold;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       rx_busy;
    logic       tx_busy;
    logic       rx_error_flag;
    logic       idle_address_tag;
    logic       break_timeout_flag;
    logic       sync_timeout_flag;
    logic       break_flag;
    logic       overrun_flag;
    logic       parity_error_flag;
    logic       framing_error_flag;
    logic       tx_done_flag;
    logic       start_flag;
    logic       rx_char_flag;
    logic       tx_buffer_empty_flag;
  } stat_t;

  typedef enum logic [4:0] {
    R_IDLE  = 5'b00001,
    R_START = 5'b00010,
    R_DATA  = 5'b00100,
    R_PAR   = 5'b01000,
    R_STOP  = 5'b10000
  } rx_state_t;

  typedef enum logic [5:0] {
    T_IDLE  = 6'b000001,
    T_GAP   = 6'b000010,
    T_START = 6'b000100,
    T_DATA  = 6'b001000,
    T_PAR   = 6'b010000,
    T_STOP  = 6'b100000
  } tx_state_t;

endpackage : uart_pkg

/* testbench/serial_peer.sv */
// Behavioural far-side serial device: frame sender and frame catcher
`timescale 1ns/1ps
module serial_peer #(
  parameter int BAUD = 4
) (
  input  wire logic       clk,
  input  wire logic       line_in,
  output logic            line_out,
  input  wire logic       send_go,
  input  wire logic [7:0] send_byte,
  output logic            send_busy,
  output logic [7:0]      rx_byte,
  output int              rx_count
);
  logic [9:0] frame;
  logic [7:0] shreg;

  // Sender: start, eight data bits LSB first, one stop
  initial
  begin
    line_out  = 1'b1;
    send_busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (send_go)
      begin
        send_busy <= 1'b1;
        frame = {1'b1, send_byte, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
          line_out <= frame[i];
          repeat (BAUD) @(posedge clk);
        end
        send_busy <= 1'b0;
      end
    end
  end

  // Catcher: mid-bit samples on the falling edge, clear of launch edges
  initial
  begin
    rx_count = 0;
    rx_byte  = 8'h00;
    forever
    begin
      @(negedge clk);
      if (line_in === 1'b0)
      begin
        repeat (BAUD / 2) @(negedge clk);
        for (int j = 0; j < 8; j++)
        begin
          repeat (BAUD) @(negedge clk);
          shreg[j] = line_in;
        end
        repeat (BAUD) @(negedge clk);
        rx_byte  = shreg;
        rx_count = rx_count + 1;
      end
    end
  end
endmodule : serial_peer

/* testbench/tb_top.sv */
// Self-checking bench for the idle-line UART transceiver
`timescale 1ns/1ps
`include "uart_consts.svh"
module tb_top;
  import uart_pkg::*;
  localparam int BD = 4;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic        clk;
  logic        nrst;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  logic        rxd;
  logic        txd;
  logic        rx_irq;
  logic        wk;
  logic        ti;
  logic        si;
  logic        di;
  logic        go;
  logic        busy;
  logic [7:0]  sb;
  logic [7:0]  pb;
  logic [31:0] q;
  int          pc;
  int          n;
  int          wakes;
  int          fail_count;
  int          samples_checked;
  row_t        rows [6] = '{
    '{1'b0, `OFS_CTRL, 32'h0, `CTRL_RESET},
    '{1'b0, `OFS_BAUD, 32'h0, `BAUD_RESET},
    '{1'b0, `OFS_STAT, 32'h0, 32'h1},
    '{1'b0, `OFS_RXBUF, 32'h0, 32'h0},
    '{1'b1, 8'h20, 32'hffff, 32'h0},
    '{1'b1, `OFS_BAUD, 32'h4, 32'h4}};

  uart_idle_line_multiproc uut (.clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .serial_receive_pin(rxd), .serial_transmit_pin(txd), .rx_irq(rx_irq), .tx_irq(ti),
    .start_irq(si), .tx_done_irq(di), .wake_req(wk));
  serial_peer #(.BAUD(BD)) peer (.clk(clk), .line_in(txd), .line_out(rxd), .send_go(go),
    .send_byte(sb), .send_busy(busy), .rx_byte(pb), .rx_count(pc));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Wake pulse counter
  always @(negedge clk)
    if (wk === 1'b1)
      wakes++;

  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : chk

  task automatic stop_if(input logic bad);
    if (bad)
    begin
      fail_count++;
      test_done();
    end
  endtask : stop_if

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wb_rsp.ack !== 1'b1 && k < 20);
    stop_if(k >= 20);
    // Data taken and request released at the edge that samples ack
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : bus

  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    @(posedge clk);
    sb <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (busy !== 1'b0 && k < 100);
    stop_if(k >= 100);
  endtask : send

  task automatic wait_rx(input int c);
    int k;
    k = 0;
    while (pc < c && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    stop_if(pc < c);
  endtask : wait_rx

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    wb_req = '0;
    go = 1'b0;
    sb = 8'h00;
    wakes = 0;
    fail_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    bus(1'b1, `OFS_CTRL, 32'h0281);
    bus(1'b1, `OFS_CTRL, 32'h0280);
    bus(1'b1, `OFS_CTRL, 32'h1280);
    send(8'h3c);
    send(8'h55);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(q & 32'h0403, 32'h0403);
    chk({31'h0, rx_irq}, 32'h1);
    bus(1'b0, `OFS_RXBUF, 32'h0);
    chk(q, 32'h3c);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk(q, 32'h1280);
    bus(1'b1, `OFS_CTRL, 32'h1080);
    send(8'ha7);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(q & 32'h0402, 32'h0002);
    repeat (12 * BD) @(posedge clk);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(q & 32'h0400, 32'h0400);
    chk(wakes, 3);
    bus(1'b1, `OFS_CTRL, 32'h1081);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(q & 32'h08f3, 32'h0001);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk(q, 32'h0081);
    chk({31'h0, rx_irq}, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h0080);
    bus(1'b1, `OFS_TXBUF, 32'h96);
    wait_rx(1);
    chk(pb, 8'h96);
    bus(1'b1, `OFS_CTRL, 32'h0880);
    bus(1'b1, `OFS_TXBUF, 32'h4b);
    n = 0;
    while (txd === 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= 11 * BD - 2 && n <= 11 * BD + 2, 32'h1);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk(q, 32'h0080);
    wait_rx(2);
    chk(pb, 8'h4b);
    // Odd parity: a peer frame of 0x01 carries a wrong parity bit
    bus(1'b1, `OFS_CTRL, 32'h0009);
    bus(1'b1, `OFS_CTRL, 32'h0008);
    send(8'h01);
    repeat (2 * BD) @(posedge clk);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(q & 32'h0822, 32'h0000);
    bus(1'b1, `OFS_CTRL, 32'h0409);
    bus(1'b1, `OFS_CTRL, 32'h0408);
    send(8'h01);
    repeat (2 * BD) @(posedge clk);
    bus(1'b0, `OFS_STAT, 32'h0);
    chk(q & 32'h0822, 32'h0822);
    // Remaining interrupt requests after a finished transmission
    bus(1'b1, `OFS_CTRL, 32'he408);
    bus(1'b1, `OFS_TXBUF, 32'h5a);
    wait_rx(3);
    repeat (3 * BD) @(posedge clk);
    chk({ti, si, di}, 32'h7);
    chk(pb, 8'h5a);
    test_done();
  end
endmodule : tb_top
